// *** src/fcr_flash_cmd.sv ***
// command decoder and read-mode controller for the main and secondary flash
`timescale 1ns/1ps
module fcr_flash_cmd
    import fcr_pkg::*;
#(
    parameter int ERASE_WIN_N = ERASE_WIN_CYC,
    parameter int GAP_N = GAP_CYC,
    parameter logic [7:0] ID_CODE = 8'h5a // arbitrary value
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // host bus pins
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic [NMAIN-1:0] main_sector_selects,
    input wire logic [NSEC-1:0] secondary_sector_selects,
    output logic [DW-1:0] rdata,
    output logic rdata_oe,
    // array and protection side
    input wire logic [DW-1:0] main_array_data,
    input wire logic [DW-1:0] sec_array_data,
    input wire logic [NMAIN-1:0] main_prot,
    input wire logic [NSEC-1:0] sec_prot,
    output logic [NMAIN-1:0] main_prot_reg,
    output logic [NSEC-1:0] sec_prot_reg,
    // embedded algorithm side
    input wire logic [1:0] alg_busy,
    input wire logic [DW-1:0] alg_status,
    output logic op_req,
    output fcr_op_t op_kind,
    output logic op_blk,
    output logic [2:0] op_sect,
    output logic [AW-1:0] op_addr,
    output logic [DW-1:0] op_data,
    output fcr_mode_t main_mode,
    output fcr_mode_t sec_mode
);

    //--------------------------------------------------------------
    // declarations
    //--------------------------------------------------------------
    logic [PIN_W-1:0] sync1_r;
    logic [PIN_W-1:0] sync2_r;
    logic wr_n_s;
    logic rd_n_s;
    logic wr_n_d_r;
    logic rd_n_d_r;
    logic [AW-1:0] adr_s;
    logic [DW-1:0] dat_s;
    logic [NMAIN-1:0] msel_s;
    logic [NSEC-1:0] ssel_s;
    logic wr_ev;
    logic rd_ev;
    logic hit;
    logic blk;
    logic is_u1;
    logic is_u2;
    logic at555;
    logic acc;
    logic gap_out;
    logic win_open;
    logic busy_b;
    fcr_mode_t mode_b;
    logic [2:0] msect;
    logic [1:0] ssect;
    logic [2:0] sect;
    logic [2:0] idsel;
    logic prot_b;
    logic [DW-1:0] arr_b;
    logic [DW-1:0] rd_src;
    fcr_step_t step_r;
    fcr_step_t step_nxt;
    fcr_ev_t ev_nxt;
    logic sblk_r;
    logic [CNTW-1:0] gap_r;
    logic [CNTW-1:0] win_r;
    logic bulk_r;
    logic [NMAIN-1:0] esmask_r;
    logic [NMAIN-1:0] esm_nxt;
    fcr_mode_t mode_r [2];
    fcr_mode_t mode_nxt [2];
    logic busy_d_r [2];
    logic susret_r [2];
    logic done_w [2];
    logic op_fire;
    fcr_op_t op_kind_nxt;
    logic op_req_r;
    fcr_op_t op_kind_r;
    logic op_blk_r;
    logic [2:0] op_sect_r;
    logic [AW-1:0] op_addr_r;
    logic [DW-1:0] op_data_r;
    logic [DW-1:0] rdata_r;
    logic rdata_oe_r;
    logic [NMAIN-1:0] mprot_r;
    logic [NSEC-1:0] sprot_r;

    // lowest active select gives the sector index
    function automatic logic [2:0] fcr_first(input logic [NMAIN-1:0] v);
        logic [2:0] i;
        i = '0;
        for (int k = NMAIN - 1; k >= 0; k--)
            if (v[k])
                i = 3'(k);
        return i;
    endfunction

    // next mode of one block
    function automatic fcr_mode_t fcr_next_mode(input fcr_mode_t m, input logic sr,
        input logic done, input logic err, input logic mine, input fcr_ev_t ev);
        fcr_mode_t n;
        n = m;
        if (done && err)
            n = M_ERROR;
        else if (done && m == M_ERASING)
            n = M_ARRAY;
        else if (mine)
        begin
            case (ev)
                E_ID: n = M_IDREAD;
                E_BYP: n = M_BYPASS;
                E_BYPX: n = M_ARRAY;
                E_SECT, E_BULK, E_RES: n = M_ERASING;
                E_SUSP: n = M_SUSP;
                E_RST:
                    if (m == M_IDREAD)
                        n = sr ? M_SUSP : M_ARRAY;
                    else if (m == M_ERROR)
                        n = M_ARRAY;
                default: n = m;
            endcase
        end
        return n;
    endfunction

    //--------------------------------------------------------------
    // pin synchronisers and strobe edges
    //--------------------------------------------------------------
    // two flops on every pin before use
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            sync1_r <= '1;
            sync2_r <= '1;
            wr_n_d_r <= 1'b1;
            rd_n_d_r <= 1'b1;
        end
        else
        begin
            sync1_r <= {wr_n, rd_n, addr, wdata, main_sector_selects,
                secondary_sector_selects};
            sync2_r <= sync1_r;
            wr_n_d_r <= wr_n_s;
            rd_n_d_r <= rd_n_s;
        end
    end

    // unpack synchronised pins, write ends on rising strobe
    assign {wr_n_s, rd_n_s, adr_s, dat_s, msel_s, ssel_s} = sync2_r;
    assign wr_ev = wr_n_s && !wr_n_d_r;
    assign rd_ev = !rd_n_s && rd_n_d_r;

    //--------------------------------------------------------------
    // address and block decode
    //--------------------------------------------------------------
    // main block wins when both are selected
    assign hit = |msel_s || |ssel_s;
    assign blk = !(|msel_s);
    assign is_u1 = adr_s[11:0] == ADR_U1 && dat_s == D_U1;
    assign is_u2 = adr_s[11:0] == ADR_U2 && dat_s == D_U2;
    assign at555 = adr_s[11:0] == ADR_U1;
    assign mode_b = mode_r[blk];
    assign busy_b = alg_busy[blk];
    assign acc = wr_ev && hit && (!busy_b || mode_b == M_ERASING);
    assign gap_out = step_r != S_IDLE && gap_r == '0;
    assign win_open = win_r != '0;

    // sector index and special-read select
    assign msect = fcr_first(msel_s);
    assign ssect = 2'(fcr_first({{(NMAIN - NSEC){1'b0}}, ssel_s}));
    assign sect = blk ? {1'b0, ssect} : msect;
    assign idsel = {adr_s[A_SEL_HI], adr_s[A_SEL_MID], adr_s[A_SEL_LO]};

    //--------------------------------------------------------------
    // instruction sequence decoder
    //--------------------------------------------------------------
    // walks unlock, command and confirmation bytes
    always_comb
    begin
        step_nxt = step_r;
        ev_nxt = E_NONE;
        if (gap_out)
            step_nxt = S_IDLE;
        if (acc)
        begin
            step_nxt = S_IDLE;
            if (step_r == S_IDLE || blk == sblk_r)
            begin
                unique case (step_r)
                    S_IDLE:
                        if (mode_b == M_ERASING)
                        begin
                            if (dat_s == C_SECT && win_open && !bulk_r)
                                ev_nxt = E_SECT;
                            else if (dat_s == C_SUSP && !bulk_r)
                                ev_nxt = E_SUSP;
                        end
                        else if (mode_b == M_BYPASS)
                        begin
                            if (dat_s == C_PROG)
                                step_nxt = S_BP;
                            else if (dat_s == C_ID)
                                step_nxt = S_BR;
                        end
                        else if (mode_b == M_SUSP && dat_s == C_SECT)
                            ev_nxt = E_RES;
                        else if (dat_s == C_RESET)
                            ev_nxt = E_RST;
                        else if (is_u1 && mode_b != M_ERROR)
                            step_nxt = S_C1;
                    S_C1:
                        if (is_u2)
                            step_nxt = S_C2;
                    S_C2:
                        if (at555 && dat_s == C_ID)
                            ev_nxt = E_ID;
                        else if (at555 && dat_s == C_PROG)
                            step_nxt = S_PD;
                        else if (at555 && dat_s == C_ERASE && mode_b != M_SUSP)
                            step_nxt = S_E3;
                        else if (at555 && dat_s == C_BYP && mode_b == M_ARRAY)
                            ev_nxt = E_BYP;
                    S_PD, S_BP:
                        if (!(mode_b == M_SUSP && esmask_r[sect]))
                            ev_nxt = E_PROG;
                    S_E3:
                        if (is_u1)
                            step_nxt = S_E4;
                    S_E4:
                        if (is_u2)
                            step_nxt = S_E5;
                    S_E5:
                        if (dat_s == C_SECT)
                            ev_nxt = E_SECT;
                        else if (at555 && dat_s == C_BULK)
                            ev_nxt = E_BULK;
                    S_BR:
                        if (dat_s == C_BYPX)
                            ev_nxt = E_BYPX;
                    default: step_nxt = S_IDLE;
                endcase
            end
        end
    end

    // step register and inter-byte gap timer
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            step_r <= S_IDLE;
            sblk_r <= 1'b0;
            gap_r <= '0;
        end
        else
        begin
            step_r <= step_nxt;
            if (acc)
            begin
                sblk_r <= blk;
                gap_r <= CNTW'(GAP_N);
            end
            else if (gap_r != '0)
                gap_r <= gap_r - 1'b1;
        end
    end

    //--------------------------------------------------------------
    // erase window and erased-sector mask
    //--------------------------------------------------------------
    // sectors of a new erase start a fresh mask
    assign esm_nxt = (mode_b == M_ERASING ? esmask_r : '0) | (NMAIN'(1) << sect);

    // window for further sector commands
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            win_r <= '0;
            bulk_r <= 1'b0;
            esmask_r <= '0;
        end
        else if (ev_nxt == E_SECT)
        begin
            win_r <= CNTW'(ERASE_WIN_N);
            bulk_r <= 1'b0;
            esmask_r <= esm_nxt;
        end
        else if (ev_nxt == E_BULK)
        begin
            win_r <= '0;
            bulk_r <= 1'b1;
            esmask_r <= '1;
        end
        else if (win_r != '0)
            win_r <= win_r - 1'b1;
    end

    //--------------------------------------------------------------
    // per-block mode state
    //--------------------------------------------------------------
    for (genvar b = 0; b < 2; b++)
    begin : g_blk
        // algorithm finished when busy falls
        assign done_w[b] = busy_d_r[b] && !alg_busy[b];
        assign mode_nxt[b] = fcr_next_mode(mode_r[b], susret_r[b], done_w[b],
            alg_status[ERR_BIT], blk == 1'(b), ev_nxt);

        // mode, busy history, return-to-suspend flag
        always_ff @(posedge mclk)
        begin
            if (rst)
            begin
                mode_r[b] <= M_ARRAY;
                busy_d_r[b] <= 1'b0;
                susret_r[b] <= 1'b0;
            end
            else
            begin
                mode_r[b] <= mode_nxt[b];
                busy_d_r[b] <= alg_busy[b];
                if (ev_nxt == E_ID && blk == 1'(b))
                    susret_r[b] <= mode_r[b] == M_SUSP;
            end
        end
    end

    //--------------------------------------------------------------
    // algorithm requests
    //--------------------------------------------------------------
    // event to request kind
    assign op_fire = ev_nxt inside {E_PROG, E_SECT, E_BULK, E_SUSP, E_RES};
    assign op_kind_nxt = ev_nxt == E_PROG ? OP_PROG
        : ev_nxt == E_SECT ? OP_SECT
        : ev_nxt == E_BULK ? OP_BULK
        : ev_nxt == E_SUSP ? OP_SUSP
        : ev_nxt == E_RES ? OP_RES : OP_NONE;

    // one-cycle request with its operands
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            op_req_r <= 1'b0;
            op_kind_r <= OP_NONE;
            op_blk_r <= 1'b0;
            op_sect_r <= '0;
            op_addr_r <= '0;
            op_data_r <= '0;
        end
        else
        begin
            op_req_r <= op_fire;
            if (op_fire)
            begin
                op_kind_r <= op_kind_nxt;
                op_blk_r <= blk;
                op_sect_r <= sect;
                op_addr_r <= adr_s;
                op_data_r <= dat_s;
            end
        end
    end

    //--------------------------------------------------------------
    // read data path
    //--------------------------------------------------------------
    // source picked by the block's mode
    assign prot_b = blk ? sec_prot[ssect] : main_prot[msect];
    assign arr_b = blk ? sec_array_data : main_array_data;
    assign rd_src = mode_b == M_ERROR ? (alg_status | ERR_MASK)
        : (busy_b || mode_b == M_ERASING) ? alg_status
        : (mode_b == M_IDREAD && idsel == ID_SEL && !blk) ? ID_CODE
        : (mode_b == M_IDREAD && idsel == PROT_SEL) ? (prot_b ? PROT_YES : PROT_NO)
        : arr_b;

    // read latch, drive enable, protection mirrors
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rdata_r <= '0;
            rdata_oe_r <= 1'b0;
            mprot_r <= '0;
            sprot_r <= '0;
        end
        else
        begin
            rdata_oe_r <= !rd_n_s && hit;
            if (rd_ev)
                rdata_r <= rd_src;
            mprot_r <= main_prot;
            sprot_r <= sec_prot;
        end
    end

    // outputs from flops
    assign rdata = rdata_r;
    assign rdata_oe = rdata_oe_r;
    assign main_prot_reg = mprot_r;
    assign sec_prot_reg = sprot_r;
    assign op_req = op_req_r;
    assign op_kind = op_kind_r;
    assign op_blk = op_blk_r;
    assign op_sect = op_sect_r;
    assign op_addr = op_addr_r;
    assign op_data = op_data_r;
    assign main_mode = mode_r[0];
    assign sec_mode = mode_r[1];

    //--------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_susp_out;
        op_req_r && op_kind_r == OP_SUSP;
    endsequence

    property p_read_no_step;
        rd_ev && !wr_ev && !gap_out |=> $stable(step_r);
    endproperty
    a_read_no_step: assert property (p_read_no_step) else $error("read moved sequence");

    property p_nosel_ignored;
        wr_ev && !hit && !gap_out |=> $stable(step_r) && !op_req_r;
    endproperty
    a_nosel_ignored: assert property (p_nosel_ignored) else $error("unselected write acted");

    property p_id_holds;
        mode_r[0] == M_IDREAD && !(ev_nxt == E_RST && !blk) && !done_w[0]
            |=> mode_r[0] == M_IDREAD;
    endproperty
    a_id_holds: assert property (p_id_holds) else $error("id mode left without reset");

    property p_win_load;
        ev_nxt == E_SECT |=> win_r == CNTW'(ERASE_WIN_N) ##1 win_r == CNTW'(ERASE_WIN_N - 1);
    endproperty
    a_win_load: assert property (p_win_load) else $error("erase window wrong");

    property p_byp_prog;
        ev_nxt == E_PROG && step_r == S_BP |-> mode_r[sblk_r] == M_BYPASS;
    endproperty
    a_byp_prog: assert property (p_byp_prog) else $error("bypass program outside bypass");

    property p_susp;
        ev_nxt == E_SUSP |-> mode_b == M_ERASING ##1 s_susp_out;
    endproperty
    a_susp: assert property (p_susp) else $error("suspend outside erase");

    property p_resume;
        op_req_r && op_kind_r == OP_RES |-> $past(mode_b) == M_SUSP;
    endproperty
    a_resume: assert property (p_resume) else $error("resume outside suspend");

    property p_reset_array;
        $fell(rst) |-> mode_r[0] == M_ARRAY && mode_r[1] == M_ARRAY && step_r == S_IDLE;
    endproperty
    a_reset_array: assert property (p_reset_array) else $error("not in array after reset");

    property p_gap;
        gap_out |=> step_r == S_IDLE;
    endproperty
    a_gap: assert property (p_gap) else $error("gap did not abort");

    property p_status_read;
        rd_ev && busy_b && mode_b != M_ERROR |=> rdata_r == $past(alg_status);
    endproperty
    a_status_read: assert property (p_status_read) else $error("busy read not status");

endmodule

// *** src/fcr_pkg.sv ***
// constants and types for the flash command decoder and read-mode controller
package fcr_pkg;

    // bus widths
    localparam int AW = 16;
    localparam int DW = 8;
    localparam int NMAIN = 8;
    localparam int NSEC = 4;
    localparam int PIN_W = 2 + AW + DW + NMAIN + NSEC;

    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int ERASE_WIN_US = 80;
    localparam int GAP_TMO_US = 80;
    localparam int ERASE_WIN_CYC = ERASE_WIN_US * 1000 / CLK_PERIOD_NS;
    localparam int GAP_CYC = GAP_TMO_US * 1000 / CLK_PERIOD_NS;
    localparam int CNTW = 15;

    // command coding
    localparam logic [11:0] ADR_U1 = 12'h555;
    localparam logic [11:0] ADR_U2 = 12'haaa;
    localparam logic [7:0] D_U1 = 8'haa;
    localparam logic [7:0] D_U2 = 8'h55;
    localparam logic [7:0] C_ID = 8'h90;
    localparam logic [7:0] C_PROG = 8'ha0;
    localparam logic [7:0] C_ERASE = 8'h80;
    localparam logic [7:0] C_SECT = 8'h30;
    localparam logic [7:0] C_BULK = 8'h10;
    localparam logic [7:0] C_SUSP = 8'hb0;
    localparam logic [7:0] C_RESET = 8'hf0;
    localparam logic [7:0] C_BYP = 8'h20;
    localparam logic [7:0] C_BYPX = 8'h00;

    // special reads
    localparam int A_SEL_HI = 6;
    localparam int A_SEL_MID = 1;
    localparam int A_SEL_LO = 0;
    localparam logic [2:0] ID_SEL = 3'h1;
    localparam logic [2:0] PROT_SEL = 3'h2;
    localparam logic [7:0] PROT_YES = 8'h01;
    localparam logic [7:0] PROT_NO = 8'h00;
    localparam int ERR_BIT = 5;
    localparam logic [7:0] ERR_MASK = 8'(1 << ERR_BIT);

    // sequence steps, unlock-to-program path in gray order
    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_C1 = 4'h1, S_C2 = 4'h3, S_PD = 4'h2, S_E3 = 4'h6,
        S_E4 = 4'h7, S_E5 = 4'h5, S_BP = 4'h4, S_BR = 4'hc
    } fcr_step_t;

    // per-block modes
    typedef enum logic [2:0] {
        M_ARRAY = 3'h0, M_IDREAD = 3'h1, M_BYPASS = 3'h3,
        M_ERASING = 3'h2, M_SUSP = 3'h6, M_ERROR = 3'h4
    } fcr_mode_t;

    // decoded events
    typedef enum logic [3:0] {
        E_NONE, E_ID, E_PROG, E_SECT, E_BULK, E_BYP, E_BYPX, E_RST, E_SUSP, E_RES
    } fcr_ev_t;

    // requests to the embedded algorithm
    typedef enum logic [2:0] {
        OP_NONE, OP_PROG, OP_SECT, OP_BULK, OP_SUSP, OP_RES
    } fcr_op_t;

endpackage

// *** tb/fcr_flash_cmd_tb.sv ***
// self-checking bench for the flash command decoder
`timescale 1ns/1ps
module fcr_flash_cmd_tb
    import fcr_pkg::*;
;
    localparam logic [7:0] ID = 8'h3c; // arbitrary value
    localparam int GAPN = 60;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] mdat = 8'h00;
    logic [7:0] sdat = 8'h00;
    logic [7:0] ast = 8'h00;
    logic [7:0] mprot = 8'h00;
    logic [3:0] sprot = 4'h0;
    logic [1:0] busy = 2'h0;
    wire wr_n, rd_n, rdata_oe, op_req, op_blk;
    wire [15:0] addr, op_addr;
    wire [7:0] wdata, msel, rdata, op_data, main_prot_reg;
    wire [3:0] ssel, sec_prot_reg;
    wire [2:0] op_sect;
    fcr_op_t op_kind;
    fcr_mode_t main_mode, sec_mode;
    int n_fail = 0;
    int cmp_count = 0;
    int n_op = 0;
    int t = 0;

    // clock and request counter
    always #2 mclk = ~mclk;
    always @(posedge mclk) if (op_req === 1'b1) n_op <= n_op + 1;

    fcr_host_model host (.mclk(mclk), .wr_n(wr_n), .rd_n(rd_n), .addr(addr), .wdata(wdata),
        .main_sector_selects(msel), .secondary_sector_selects(ssel), .rdata(rdata));

    fcr_flash_cmd #(.ERASE_WIN_N(40), .GAP_N(GAPN), .ID_CODE(ID)) fcr_flash_cmd_inst (
        .mclk(mclk), .rst(rst), .wr_n(wr_n), .rd_n(rd_n), .addr(addr), .wdata(wdata),
        .main_sector_selects(msel), .secondary_sector_selects(ssel), .rdata(rdata),
        .rdata_oe(rdata_oe), .main_array_data(mdat), .sec_array_data(sdat),
        .main_prot(mprot), .sec_prot(sprot), .main_prot_reg(main_prot_reg),
        .sec_prot_reg(sec_prot_reg), .alg_busy(busy), .alg_status(ast), .op_req(op_req),
        .op_kind(op_kind), .op_blk(op_blk), .op_sect(op_sect), .op_addr(op_addr),
        .op_data(op_data), .main_mode(main_mode), .sec_mode(sec_mode));

    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one new request of the given kind since count n0
    task automatic op_is(input fcr_op_t k, input int n0);
        chk(16'(n_op - n0), 16'h1);
        chk(16'(op_kind), 16'(k));
    endtask

    // expected answer of a protection-status read
    function automatic logic [7:0] prot_byte(input logic p);
        return p ? PROT_YES : PROT_NO;
    endfunction

    task automatic done();
        t++;
        $display("test %0d done", t);
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        logic [7:0] q;
        logic [15:0] pa;
        logic [7:0] pd;
        logic [2:0] s;
        int n0;
        void'($urandom(14));
        repeat (4) @(posedge mclk);
        #1 rst = 1'b0;
        host.tick(3);
        chk(16'({main_mode, sec_mode, rdata_oe}), 16'({M_ARRAY, M_ARRAY, 1'b0}));
        // plain reads of both blocks
        repeat (4)
        begin
            mdat = 8'($urandom);
            sdat = 8'($urandom);
            s = 3'($urandom);
            host.rd(16'($urandom), 1'b0, s, q);
            chk(16'(q), 16'(mdat));
            host.rd(16'($urandom), 1'b1, s & 3'h3, q);
            chk(16'(q), 16'(sdat));
        end
        done();
        // identifier read, held until reset command
        host.unlock(1'b0, s, C_ID);
        repeat (2)
        begin
            host.rd({4'($urandom), 12'h001}, 1'b0, s, q);
            chk(16'(q), 16'(ID));
        end
        chk(16'(main_mode), 16'(M_IDREAD));
        host.wr(16'($urandom), C_RESET, 1'b0, s);
        chk(16'(main_mode), 16'(M_ARRAY));
        // protection read on the secondary block
        sprot = 4'($urandom);
        mprot = 8'($urandom);
        s = 3'($urandom % 4);
        host.unlock(1'b1, s, C_ID);
        host.rd(16'h0002, 1'b1, s, q);
        chk(16'(q), 16'(prot_byte(sprot[s[1:0]])));
        chk({main_prot_reg, sec_prot_reg}, {mprot, sprot});
        host.wr(16'h0000, C_RESET, 1'b1, s);
        chk(16'(sec_mode), 16'(M_ARRAY));
        done();
        // program, then bypass program without entry
        pa = 16'($urandom);
        pd = 8'($urandom);
        n0 = n_op;
        host.unlock(1'b0, s, C_PROG);
        host.wr(pa, pd, 1'b0, s);
        op_is(OP_PROG, n0);
        chk({op_addr[7:0], op_data}, {pa[7:0], pd});
        host.wr(16'h0000, C_PROG, 1'b0, s);
        host.wr(pa, pd, 1'b0, s);
        chk(16'(n_op - n0), 16'h1);
        // bypass entry, program, reset ignored, bypass exit
        host.unlock(1'b0, s, C_BYP);
        chk(16'(main_mode), 16'(M_BYPASS));
        host.wr(16'($urandom), C_PROG, 1'b0, s);
        host.wr(pa, pd ^ 8'hff, 1'b0, s);
        op_is(OP_PROG, n0 + 1);
        chk(16'(op_data), 16'(pd ^ 8'hff));
        host.wr(16'h0000, C_RESET, 1'b0, s);
        chk(16'(main_mode), 16'(M_BYPASS));
        host.wr(16'h0000, C_ID, 1'b0, s);
        host.wr(16'h0000, C_BYPX, 1'b0, s);
        chk(16'(main_mode), 16'(M_ARRAY));
        done();
        // suspend and resume outside an erase do nothing
        n0 = n_op;
        host.wr(16'h0000, C_SUSP, 1'b0, s);
        host.wr(16'h0000, C_SECT, 1'b0, s);
        chk(16'(n_op - n0), 16'h0);
        // coded sequence with no sector selected is ignored
        host.unlock(1'b1, 3'h4, C_ID);
        chk(16'({main_mode, sec_mode}), 16'({M_ARRAY, M_ARRAY}));
        // sector erase, status reads, suspend, resume, error
        host.unlock(1'b0, s, C_ERASE);
        host.unlock(1'b0, s, C_SECT);
        op_is(OP_SECT, n0);
        chk(16'({op_blk, op_sect}), 16'({1'b0, s}));
        host.wr(16'h0000, C_SECT, 1'b0, s ^ 3'h2);
        op_is(OP_SECT, n0 + 1);
        host.tick(50);
        n0 = n_op;
        host.wr(16'h0000, C_SECT, 1'b0, s ^ 3'h4);
        chk(16'(n_op - n0), 16'h0);
        ast = 8'($urandom) & ~ERR_MASK;
        host.rd(16'h0000, 1'b0, s, q);
        chk(16'(q), 16'(ast));
        host.wr(16'h0000, C_SUSP, 1'b0, s);
        op_is(OP_SUSP, n0);
        host.rd(16'($urandom), 1'b0, s ^ 3'h1, q);
        chk(16'(q), 16'(mdat));
        // program allowed outside the erased sectors only
        host.unlock(1'b0, s ^ 3'h1, C_PROG);
        host.wr(pa, pd, 1'b0, s ^ 3'h1);
        op_is(OP_PROG, n0 + 1);
        host.unlock(1'b0, s, C_PROG);
        host.wr(pa, pd, 1'b0, s);
        chk(16'(n_op - n0), 16'h2);
        host.wr(16'h0000, C_SECT, 1'b0, s);
        op_is(OP_RES, n0 + 2);
        chk(16'(main_mode), 16'(M_ERASING));
        busy = 2'h1;
        ast = ast | ERR_MASK;
        host.rd(16'h0000, 1'b0, s, q);
        chk(16'(q), 16'(ast));
        busy = 2'h0;
        host.tick(3);
        ast = ast & ~ERR_MASK;
        host.rd(16'h0000, 1'b0, s, q);
        chk(16'(q), 16'(ast | ERR_MASK));
        chk(16'(main_mode), 16'(M_ERROR));
        host.wr(16'h0000, C_RESET, 1'b0, s);
        chk(16'(main_mode), 16'(M_ARRAY));
        done();
        // too long a gap between coded bytes aborts the sequence
        host.wr(16'h0555, D_U1, 1'b0, s);
        host.tick(GAPN + 20);
        host.wr(16'h0aaa, D_U2, 1'b0, s);
        host.wr(16'h0555, C_ID, 1'b0, s);
        chk(16'(main_mode), 16'(M_ARRAY));
        done();
        wrap_up();
    end
endmodule

// *** tb/fcr_host_model.sv ***
// host bus model: write and read cycles on the flash pins
`timescale 1ns/1ps
module fcr_host_model
    import fcr_pkg::*;
(
    // clock
    input wire logic mclk,
    // host bus pins
    output logic wr_n,
    output logic rd_n,
    output logic [AW-1:0] addr,
    output logic [DW-1:0] wdata,
    output logic [NMAIN-1:0] main_sector_selects,
    output logic [NSEC-1:0] secondary_sector_selects,
    input wire logic [DW-1:0] rdata
);
    // strobes and selects idle from power-up
    initial
    begin
        wr_n = 1'b1;
        rd_n = 1'b1;
        addr = 16'h0000;
        wdata = 8'h00;
        main_sector_selects = 8'h00;
        secondary_sector_selects = 4'h0;
    end

    // wait n edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // one sector selected, none for a secondary index above 3, address settled ahead of the strobe
    task automatic setup(input logic [AW-1:0] a, input logic blk, input logic [2:0] s);
        addr = a;
        main_sector_selects = blk ? 8'h00 : 8'(1 << s);
        secondary_sector_selects = blk ? 4'(1 << s) : 4'h0;
        tick(3);
    endtask

    // released selects drop to none, address and data show the inverse of their last value
    task automatic park();
        main_sector_selects = 8'h00;
        secondary_sector_selects = 4'h0;
        addr = ~addr;
        wdata = ~wdata;
        tick(2);
    endtask

    // one write cycle, held well past the strobe rise
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic blk,
        input logic [2:0] s);
        wdata = d;
        setup(a, blk, s);
        wr_n = 1'b0;
        tick(2);
        wr_n = 1'b1;
        tick(4);
        park();
    endtask

    // one read cycle, data taken while the strobe is still low
    task automatic rd(input logic [AW-1:0] a, input logic blk, input logic [2:0] s,
        output logic [DW-1:0] q);
        setup(a, blk, s);
        rd_n = 1'b0;
        tick(5);
        q = rdata;
        rd_n = 1'b1;
        tick(4);
        park();
    endtask

    // coded pair then command byte, upper address bits random
    task automatic unlock(input logic blk, input logic [2:0] s, input logic [DW-1:0] c);
        wr({4'($urandom), ADR_U1}, D_U1, blk, s);
        wr({4'($urandom), ADR_U2}, D_U2, blk, s);
        wr({4'($urandom), ADR_U1}, c, blk, s);
    endtask
endmodule
